// File: dv/mfs_env_model.sv
// Far-side model: alert line pull-up and the gate stage behind the block
`timescale 1ns/1ns
`default_nettype none
module mfs_env_model (
  input  wire logic               alert_out,
  input  wire logic               alert_oe,
  input  wire mfs_pkg::mfs_gate_e gate_mode,
  output logic                    alert_pin,
  output logic                    fets_conduct
);
  import mfs_pkg::*;
  // Released open-drain line goes to the pull-up level, never the last value
  assign alert_pin    = alert_oe ? alert_out : 1'b1;
  // FETs switch only while the block allows normal operation
  assign fets_conduct = (gate_mode == MFS_GATE_NORMAL);
endmodule
`default_nettype wire

// File: dv/test_motor_fault_supervisor.sv
// Testbench of the motor fault supervisor
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; \
  if ((got) !== (ex)) begin err_total++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module test_motor_fault_supervisor;
  import mfs_pkg::*;
  // Short millisecond keeps the restart delays inside the run budget
  localparam int unsigned CMS = 2;
  localparam int unsigned HB[3] = '{FLG_OCUR, FLG_THERM, FLG_PUMP};
  localparam logic [15:0] FM[3] = '{MAX_SPEED_LIMIT_0, MAX_SPEED_LIMIT_1, MAX_SPEED_LIMIT_2};
  localparam logic [15:0] FS[4] = '{FST_0, FST_1, FST_2, FST_3};
  logic       mclk;
  logic       sys_rst;
  logic       ce;
  mfs_cfg_s   cfg;
  mfs_sense_s sense;
  logic [7:0] fault_flags;
  mfs_gate_e  gate_mode;
  logic       halt;
  logic       error_mode;
  logic       alert_out;
  logic       alert_oe;
  logic       alert_pin;
  logic       fets_conduct;
  int         err_total;
  int         num_checks;

  mfs_supervisor #(.CYC_MS(CMS)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .cfg(cfg), .sense(sense),
    .fault_flags(fault_flags), .gate_mode(gate_mode), .halt(halt),
    .error_mode(error_mode), .alert_out(alert_out), .alert_oe(alert_oe));
  mfs_env_model env (
    .alert_out(alert_out), .alert_oe(alert_oe), .gate_mode(gate_mode),
    .alert_pin(alert_pin), .fets_conduct(fets_conduct));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic idle();
    sense = '0;
    sense.sensorless_run = 1'b1;
    sense.rot_freq = 16'h0100;
  endtask

  task automatic wait_err(input logic ex, input int mx);
    int i;
    i = 0;
    while (error_mode !== ex && i < mx) begin
      step(1);
      i++;
    end
    `CHK("error_mode", ex, error_mode)
  endtask

  task automatic chk_out(input logic [7:0] f, input mfs_gate_e g,
                         input logic e);
    `CHK("fault_flags", f, fault_flags)
    `CHK("gate_mode", g, gate_mode)
    `CHK("error_mode", e, error_mode)
    `CHK("alert_pin", cfg.alert_invert ^ e, alert_pin)
    `CHK("fets_conduct", g == MFS_GATE_NORMAL, fets_conduct)
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      sense.round_done = 1'b1;
      step(1);
      sense.round_done = 1'b0;
      step(1);
    end
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_hard();
    for (int k = 0; k < 3; k++) begin
      cfg.alert_invert = k[0];
      sense.overcurrent = (k == 0);
      sense.thermal_trip = (k == 1);
      sense.pump_undervolt_detect = (k == 2);
      step(1);
      chk_out(8'h01 << HB[k], MFS_GATE_OFF, 1'b1);
      step(20);
      `CHK("held_err", 1'b1, error_mode)
      idle();
      wait_err(1'b0, 6);
      chk_out(8'h00, MFS_GATE_NORMAL, 1'b0);
    end
    cfg.alert_invert = 1'b0;
  endtask

  task automatic t_over();
    for (int l = 0; l < 3; l++) begin
      cfg.max_speed_limit = l[1:0];
      sense.rot_freq = FM[l];
      step(2);
      `CHK("at_limit", 1'b0, error_mode)
      sense.rot_freq = FM[l] + 16'h0001;
      step(1);
      chk_out(8'h04, MFS_GATE_OFF, 1'b1);
      idle();
      wait_err(1'b0, 6);
    end
    cfg.max_speed_limit = MAX_SPEED_LIMIT_NONE;
    sense.rot_freq = 16'hFFFF;
    step(2);
    `CHK("no_limit", 1'b0, error_mode)
    idle();
  endtask

  task automatic t_under();
    for (int f = 0; f < 4; f++) begin
      cfg.forced_commutation_freq = f[1:0];
      cfg.stall_reaction_sel = 1'b1;
      sense.rot_freq = FS[f];
      step(2);
      `CHK("at_fst", 1'b0, error_mode)
      sense.rot_freq = FS[f] - 16'h0001;
      step(1);
      chk_out(8'h02, MFS_GATE_BRAKE, 1'b1);
      cfg.stall_reaction_sel = 1'b0;
      step(1);
      `CHK("gate_sel0", MFS_GATE_OFF, gate_mode)
      idle();
      wait_err(1'b0, 6);
    end
  endtask

  task automatic t_start();
    sense.sensorless_run = 1'b0;
    cfg.startup_check_disable = 1'b1;
    pulses(4);
    step(3);
    `CHK("start_off", 1'b0, error_mode)
    sense.sensorless_run = 1'b1;
    step(1);
    sense.sensorless_run = 1'b0;
    cfg.startup_check_disable = 1'b0;
    pulses(3);
    step(3);
    `CHK("three_rounds", 1'b0, error_mode)
    pulses(1);
    wait_err(1'b1, 3);
    chk_out(8'h01, MFS_GATE_OFF, 1'b1);
    idle();
    wait_err(1'b0, 6);
  endtask

  task automatic t_latch();
    cfg.recover_latched = 1'b1;
    for (int r = 0; r < 2; r++) begin
      sense.overcurrent = 1'b1;
      step(1);
      sense.overcurrent = 1'b0;
      step(60);
      `CHK("latched", 1'b1, error_mode)
      sense.speed_zero = (r == 0);
      sense.standby = (r == 1);
      wait_err(1'b0, 4);
      chk_out(8'h00, MFS_GATE_NORMAL, 1'b0);
      idle();
      step(1);
    end
    cfg.recover_latched = 1'b0;
  endtask

  task automatic t_auto();
    cfg.restart_delay_sel = 3'h1;
    sense.thermal_trip = 1'b1;
    step(1);
    sense.thermal_trip = 1'b0;
    step(CMS * 500 - 20);
    `CHK("before_tre", 1'b1, error_mode)
    wait_err(1'b0, 40);
    cfg.restart_delay_sel = 3'h7;
    sense.overcurrent = 1'b1;
    step(1);
    sense.overcurrent = 1'b0;
    step(5);
    sense.standby = 1'b1;
    wait_err(1'b0, 4);
    idle();
    cfg.restart_delay_sel = 3'h0;
    step(1);
  endtask

  // Reset in mid-run, while error mode stands, must clear everything
  task automatic t_reset();
    sense.overcurrent = 1'b1;
    step(1);
    `CHK("pre_rst_err", 1'b1, error_mode)
    sys_rst = 1'b1;
    step(2);
    `CHK("rst_flags", 8'h00, fault_flags)
    `CHK("rst_err", 1'b0, error_mode)
    `CHK("rst_halt", 1'b0, halt)
    idle();
    sys_rst = 1'b0;
    step(2);
    chk_out(8'h00, MFS_GATE_NORMAL, 1'b0);
  endtask

  task automatic t_uv();
    sense.overcurrent = 1'b1;
    step(1);
    sense.supply_undervolt = 1'b1;
    step(1);
    `CHK("halt", 1'b1, halt)
    `CHK("uv_flags", 8'h00, fault_flags)
    `CHK("uv_alert", 1'b1, alert_pin)
    idle();
    step(2);
    `CHK("halt_gone", 1'b0, halt)
    wait_err(1'b0, 6);
  endtask

  // ********************************************************************
  // Run control
  // ********************************************************************
  task automatic final_report();
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Whole sequence needs about 1300 cycles; over twenty times that is a hang
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    final_report();
  end

  initial begin
    err_total = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    ce = 1'b1;
    cfg = '0;
    cfg.max_speed_limit = MAX_SPEED_LIMIT_NONE;
    idle();
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    step(2);
    chk_out(8'h00, MFS_GATE_NORMAL, 1'b0);
    t_hard();
    t_over();
    t_under();
    t_start();
    t_latch();
    t_auto();
    t_reset();
    t_uv();
    final_report();
  end
endmodule
`default_nettype wire

// File: logic/mfs_pkg.sv
// Package: constants, encodings and carriers of the motor fault supervisor
package mfs_pkg;

  // ********************************************************************
  // Clock and restart timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned MS_W          = 14;
  // Restart times in milliseconds, codes 000 to 111
  localparam logic [MS_W-1:0] RESTART_MS0 = 14'h0000;
  localparam logic [MS_W-1:0] RESTART_MS1 = 14'h01F4;
  localparam logic [MS_W-1:0] RESTART_MS2 = 14'h03E8;
  localparam logic [MS_W-1:0] RESTART_MS3 = 14'h05DC;
  localparam logic [MS_W-1:0] RESTART_MS4 = 14'h07D0;
  localparam logic [MS_W-1:0] RESTART_MS5 = 14'h0FA0;
  localparam logic [MS_W-1:0] RESTART_MS6 = 14'h1B58;
  localparam logic [MS_W-1:0] RESTART_MS7 = 14'h2710;

  // ********************************************************************
  // Register map and fault flag positions
  // ********************************************************************
  localparam logic [7:0] FAULT_FLAGS_ADDR = 8'h00;
  localparam logic [7:0] FAULT_FLAGS_RST  = 8'h00;
  localparam int unsigned FLG_START = 0;
  localparam int unsigned FLG_UNDER = 1;
  localparam int unsigned FLG_OVER  = 2;
  localparam int unsigned FLG_OCUR  = 3;
  localparam int unsigned FLG_THERM = 4;
  localparam int unsigned FLG_PUMP  = 5;
  localparam int unsigned START_ROUNDS = 4;

  // ********************************************************************
  // Speed thresholds, rotation frequency in units of 0.1 Hz
  // ********************************************************************
  localparam int unsigned FREQ_W = 16;
  localparam logic [FREQ_W-1:0] MAX_SPEED_LIMIT_0 = 16'h1D4C;
  localparam logic [FREQ_W-1:0] MAX_SPEED_LIMIT_1 = 16'h3A98;
  localparam logic [FREQ_W-1:0] MAX_SPEED_LIMIT_2 = 16'h7530;
  localparam logic [1:0]        MAX_SPEED_LIMIT_NONE = 2'h3;
  localparam logic [FREQ_W-1:0] FST_0 = 16'h0010;
  localparam logic [FREQ_W-1:0] FST_1 = 16'h0020;
  localparam logic [FREQ_W-1:0] FST_2 = 16'h0040;
  localparam logic [FREQ_W-1:0] FST_3 = 16'h0080;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [2:0] {
    MFS_RUN  = 3'b001,
    MFS_ERR  = 3'b010,
    MFS_HALT = 3'b100
  } mfs_state_e;

  typedef enum logic [1:0] {
    MFS_GATE_NORMAL = 2'h0,
    MFS_GATE_OFF    = 2'h1,
    MFS_GATE_BRAKE  = 2'h2
  } mfs_gate_e;

  typedef struct packed {
    logic       recover_latched;
    logic       stall_reaction_sel;
    logic       alert_invert;
    logic [2:0] restart_delay_sel;
    logic [1:0] max_speed_limit;
    logic [1:0] forced_commutation_freq;
    logic       startup_check_disable;
  } mfs_cfg_s;

  typedef struct packed {
    logic              supply_undervolt;
    logic              overcurrent;
    logic              pump_undervolt_detect;
    logic              thermal_trip;
    logic              sensorless_run;
    logic              round_done;
    logic              speed_zero;
    logic              standby;
    logic [FREQ_W-1:0] rot_freq;
  } mfs_sense_s;

endpackage

// File: logic/mfs_restart_timer.sv
// Restart timer: counts the selected restart delay in milliseconds
`timescale 1ns/1ns
`default_nettype none
module mfs_restart_timer #(
  parameter int unsigned CYC_MS = mfs_pkg::CYC_PER_MS
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [2:0] code,
  output logic            done
);
  import mfs_pkg::*;

  initial begin
    if (CYC_MS < 1) begin
      $error("CYC_MS must be at least one");
    end
  end

  function automatic logic [MS_W-1:0] restart_ms(input logic [2:0] c);
    logic [MS_W-1:0] t;
    t = RESTART_MS0;
    unique case (c)
      3'h0: t = RESTART_MS0;
      3'h1: t = RESTART_MS1;
      3'h2: t = RESTART_MS2;
      3'h3: t = RESTART_MS3;
      3'h4: t = RESTART_MS4;
      3'h5: t = RESTART_MS5;
      3'h6: t = RESTART_MS6;
      3'h7: t = RESTART_MS7;
    endcase
    return t;
  endfunction

  logic [31:0]     pre;
  logic [MS_W-1:0] ms_cnt;
  logic [MS_W-1:0] target;

  assign target = restart_ms(code);

  // ********************************************************************
  // Millisecond prescaler and delay counter
  // ********************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pre    <= 32'h0;
      ms_cnt <= 14'h0;
    end else if (ce) begin
      if (start || done) begin
        pre    <= 32'h0;
        ms_cnt <= 14'h0;
      end else if (pre == CYC_MS - 1) begin
        pre    <= 32'h0;
        ms_cnt <= ms_cnt + 14'h1;
      end else begin
        pre <= pre + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else if (ce) begin
      // Done stays up until the next start; counting halts meanwhile
      if (start) begin
        done <= 1'b0;
      end else if (ms_cnt >= target) begin
        done <= 1'b1;
      end
    end
  end

  done_time_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(done) |-> $past(ms_cnt) >= $past(target))
    else $error("restart timer finished early");

endmodule
`default_nettype wire

// File: logic/mfs_supervisor.sv
// Motor fault supervisor: fault detection, error mode, recovery and alert
`timescale 1ns/1ns
`default_nettype none
module mfs_supervisor #(
  parameter int unsigned CYC_MS = mfs_pkg::CYC_PER_MS
) (
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire logic               ce,
  input  wire mfs_pkg::mfs_cfg_s   cfg,
  input  wire mfs_pkg::mfs_sense_s sense,
  output logic [7:0]              fault_flags,
  output var mfs_pkg::mfs_gate_e   gate_mode,
  output logic                    halt,
  output logic                    error_mode,
  output logic                    alert_out,
  output logic                    alert_oe
);
  import mfs_pkg::*;

  initial begin
    if (CYC_MS < 1) begin
      $error("CYC_MS must be at least one");
    end
  end

  // ********************************************************************
  // Threshold and reaction functions
  // ********************************************************************
  function automatic logic [FREQ_W-1:0] max_limit(input logic [1:0] c);
    logic [FREQ_W-1:0] f;
    f = MAX_SPEED_LIMIT_0;
    unique case (c)
      2'h0: f = MAX_SPEED_LIMIT_0;
      2'h1: f = MAX_SPEED_LIMIT_1;
      2'h2: f = MAX_SPEED_LIMIT_2;
      2'h3: f = MAX_SPEED_LIMIT_2;
    endcase
    return f;
  endfunction

  function automatic logic [FREQ_W-1:0] min_limit(input logic [1:0] c);
    logic [FREQ_W-1:0] f;
    f = FST_0;
    unique case (c)
      2'h0: f = FST_0;
      2'h1: f = FST_1;
      2'h2: f = FST_2;
      2'h3: f = FST_3;
    endcase
    return f;
  endfunction

  function automatic mfs_gate_e gate_fn(input logic [7:0] fl,
                                        input logic       brk);
    mfs_gate_e g;
    g = MFS_GATE_NORMAL;
    if (fl[FLG_PUMP:FLG_OVER] != 4'h0) begin
      g = MFS_GATE_OFF;
    end else if (fl[FLG_UNDER:FLG_START] != 2'h0) begin
      g = brk ? MFS_GATE_BRAKE : MFS_GATE_OFF;
    end
    return g;
  endfunction

  // ********************************************************************
  // Detection
  // ********************************************************************
  mfs_state_e state;
  mfs_state_e next_state;
  logic [7:0] det;
  logic [7:0] next_flags;
  logic [2:0] rounds;
  logic       any_det;
  logic       release_ev;
  logic       hard_clear;
  logic       timer_done;
  logic       timer_start;
  logic       inv_q;

  always_comb begin
    det = 8'h00;
    det[FLG_OCUR]  = sense.overcurrent;
    det[FLG_THERM] = sense.thermal_trip;
    det[FLG_PUMP]  = sense.pump_undervolt_detect;
    det[FLG_OVER]  = (cfg.max_speed_limit != MAX_SPEED_LIMIT_NONE) &&
                     (sense.rot_freq > max_limit(cfg.max_speed_limit));
    // Underspeed only means something once sensorless drive runs
    det[FLG_UNDER] = sense.sensorless_run &&
                     (sense.rot_freq < min_limit(cfg.forced_commutation_freq));
    det[FLG_START] = !cfg.startup_check_disable &&
                     (rounds == 3'(START_ROUNDS));
  end

  assign any_det    = det != 8'h00;
  assign release_ev = sense.speed_zero || sense.standby;
  // A hard fault stays until its own cause is gone
  assign hard_clear = !((fault_flags[FLG_OCUR]  && sense.overcurrent) ||
                        (fault_flags[FLG_THERM] && sense.thermal_trip) ||
                        (fault_flags[FLG_PUMP]  &&
                         sense.pump_undervolt_detect));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rounds <= 3'h0;
    end else if (ce) begin
      if (state != MFS_RUN || sense.sensorless_run) begin
        rounds <= 3'h0;
      end else if (sense.round_done && rounds != 3'(START_ROUNDS)) begin
        rounds <= rounds + 3'h1;
      end
    end
  end

  // ********************************************************************
  // Mode sequencing
  // ********************************************************************
  always_comb begin
    next_state = state;
    next_flags = fault_flags;
    unique case (state)
      MFS_RUN: begin
        if (any_det) begin
          next_state = MFS_ERR;
          next_flags = det;
        end
      end
      MFS_ERR: begin
        next_flags = fault_flags | det;
        // A fresh detection holds error mode, so no event is lost on exit
        if (!any_det && hard_clear &&
            (release_ev || (!cfg.recover_latched && timer_done))) begin
          next_state = MFS_RUN;
          next_flags = 8'h00;
        end
      end
      MFS_HALT: begin
        next_state = MFS_RUN;
        next_flags = 8'h00;
      end
      default: begin
        next_state = MFS_HALT;
        next_flags = 8'h00;
      end
    endcase
    if (sense.supply_undervolt) begin
      next_state = MFS_HALT;
      next_flags = 8'h00;
    end
  end

  assign timer_start = (state != MFS_ERR) && (next_state == MFS_ERR);

  mfs_restart_timer #(
    .CYC_MS (CYC_MS)
  ) u_timer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .start   (timer_start),
    .code    (cfg.restart_delay_sel),
    .done    (timer_done)
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= MFS_RUN;
      fault_flags <= FAULT_FLAGS_RST;
    end else if (ce) begin
      state       <= next_state;
      fault_flags <= next_flags;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_mode  <= MFS_GATE_NORMAL;
      halt       <= 1'b0;
      error_mode <= 1'b0;
    end else if (ce) begin
      halt       <= next_state == MFS_HALT;
      error_mode <= next_state == MFS_ERR;
      if (next_state == MFS_HALT) begin
        gate_mode <= MFS_GATE_OFF;
      end else begin
        gate_mode <= gate_fn(next_flags, cfg.stall_reaction_sel);
      end
    end
  end

  // Open drain: the pin is only ever pulled low, never driven high
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_out <= 1'b0;
      alert_oe  <= 1'b1;
      inv_q     <= 1'b0;
    end else if (ce) begin
      alert_out <= 1'b0;
      inv_q     <= cfg.alert_invert;
      alert_oe  <= cfg.alert_invert == (next_state != MFS_RUN);
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  sequence run_to_err;
    ce && state == MFS_RUN && any_det && !sense.supply_undervolt;
  endsequence

  sequence err_then_run;
    state == MFS_ERR ##1 state == MFS_RUN;
  endsequence

  err_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
    run_to_err |=> state == MFS_ERR && error_mode && fault_flags != 8'h00)
    else $error("abnormality did not enter error mode");

  uv_halt_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && sense.supply_undervolt |=> halt && gate_mode == MFS_GATE_OFF
      && fault_flags == 8'h00)
    else $error("undervoltage did not halt");

  hard_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
    error_mode && fault_flags[FLG_PUMP:FLG_OVER] != 4'h0
      |-> gate_mode == MFS_GATE_OFF)
    else $error("hard fault left gates on");

  stall_brake_a: assert property (@(posedge mclk) disable iff (sys_rst)
    error_mode && $past(ce) && fault_flags[FLG_PUMP:FLG_OVER] == 4'h0
      |-> gate_mode == ($past(cfg.stall_reaction_sel) ?
                        MFS_GATE_BRAKE : MFS_GATE_OFF))
    else $error("stall reaction wrong");

  ocur_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    run_to_err and sense.overcurrent |=> fault_flags[FLG_OCUR])
    else $error("overcurrent flag missing");

  overspeed_a: assert property (@(posedge mclk) disable iff (sys_rst)
    run_to_err and cfg.max_speed_limit == 2'h0 && sense.rot_freq > MAX_SPEED_LIMIT_0
      |=> fault_flags[FLG_OVER])
    else $error("overspeed flag missing");

  underspeed_a: assert property (@(posedge mclk) disable iff (sys_rst)
    run_to_err and sense.sensorless_run && sense.rot_freq < FST_0
      |=> fault_flags[FLG_UNDER])
    else $error("underspeed flag missing");

  startup_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(fault_flags[FLG_START])
      |-> $past(rounds) == 3'h4 && !$past(cfg.startup_check_disable))
    else $error("startup failure flagged wrongly");

  latch_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && state == MFS_ERR && cfg.recover_latched && !release_ev
      && !sense.supply_undervolt |=> state == MFS_ERR)
    else $error("latched error left without release");

  auto_exit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && state == MFS_ERR && !cfg.recover_latched && timer_done
      && hard_clear && !any_det |=> state == MFS_RUN)
    else $error("automatic recovery missed");

  release_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && state == MFS_ERR && release_ev && hard_clear && !any_det
      |=> state == MFS_RUN)
    else $error("release event ignored");

  cause_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state == MFS_ERR && fault_flags[FLG_THERM] && sense.thermal_trip
      |=> state != MFS_RUN)
    else $error("left error with thermal cause present");

  exit_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    err_then_run |-> fault_flags == 8'h00 && !error_mode
      && alert_oe == !inv_q)
    else $error("exit did not clear flags or alert");

  alert_pol_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(ce) |-> alert_oe == (inv_q == (error_mode || halt)) && !alert_out)
    else $error("alert level wrong");

endmodule
`default_nettype wire
